// [hw/nfr_pkg.sv]
// Package: register map, field layout and mode types of the NAND register slice
package nfr_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [31:0] STATUS_OFF   = 32'h400e0008;
	localparam logic [31:0] IRQ_EN_OFF   = 32'h400e000c;
	localparam logic [31:0] IRQ_DIS_OFF  = 32'h400e0010;
	localparam logic [31:0] IRQ_MASK_OFF = 32'h400e0014;
	localparam logic [31:0] ADDR0_OFF    = 32'h400e0018;
	localparam logic [31:0] BANK_OFF     = 32'h400e001c;
	localparam logic [31:0] PCTRL_OFF    = 32'h400e0020;
	localparam logic [31:0] PMODE_OFF    = 32'h400e0024;

	// ==========================================================
	// Interrupt source bit positions
	localparam int RISE_BIT    = 4;
	localparam int FALL_BIT    = 5;
	localparam int XFER_BIT    = 16;
	localparam int CMD_BIT     = 17;
	localparam int DTO_BIT     = 20;
	localparam int UNMAP_BIT   = 21;
	localparam int BUSY_BIT    = 22;
	localparam int SIZE_BIT    = 23;
	localparam int LEDGE_BIT   = 24;
	localparam int NUM_SRC     = 9;
	localparam logic [31:0] SRC_MASK = 32'h01f30030;

	// ==========================================================
	// Field layout and reset values
	localparam int PAR_CLR_BIT   = 0;
	localparam int SOFT_RST_BIT  = 1;
	localparam int PS_LSB        = 0;
	localparam int CT_LSB        = 4;
	localparam int BANK_W        = 3;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [7:0]  ADDR0_RST = 8'h00;

	typedef enum logic [1:0] {
		PS_512_16  = 2'h0,
		PS_1024_32 = 2'h1,
		PS_2048_64 = 2'h2,
		PS_4096_128 = 2'h3
	} nfr_page_t;

	typedef enum logic [1:0] {
		CT_PAGE = 2'h0,
		CT_256  = 2'h1,
		CT_512  = 2'h2,
		CT_RSVD = 2'h3
	} nfr_corr_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} nfr_bus_t;

	typedef struct packed {
		nfr_page_t   page_size_sel;
		nfr_corr_t   correction_type;
		logic [12:0] main_bytes;
		logic [7:0]  spare_bytes;
		logic [9:0]  corr_span;
	} nfr_ecc_cfg_t;

	// Event inputs in source order: rise, fall, xfer, cmd, dto, unmap, busy, size, ledge
	localparam int SRC_POS [NUM_SRC] = '{4, 5, 16, 17, 20, 21, 22, 23, 24};

	localparam logic [12:0] MAIN_512  = 13'h0200;
	localparam logic [12:0] MAIN_1024 = 13'h0400;
	localparam logic [12:0] MAIN_2048 = 13'h0800;
	localparam logic [12:0] MAIN_4096 = 13'h1000;
	localparam logic [7:0]  SPARE_16  = 8'h10;
	localparam logic [7:0]  SPARE_32  = 8'h20;
	localparam logic [7:0]  SPARE_64  = 8'h40;
	localparam logic [7:0]  SPARE_128 = 8'h80;
	localparam logic [9:0]  SPAN_256  = 10'h100;
	localparam logic [9:0]  SPAN_512  = 10'h200;
	localparam logic [9:0]  SPAN_PAGE = 10'h000;

endpackage

// [hw/nfr_ecc_decode.sv]
// ECC mode decoder: page geometry and correction span
`timescale 1ns/1ps
module nfr_ecc_decode (
	input  nfr_pkg::nfr_page_t    page_sel,
	input  nfr_pkg::nfr_corr_t    corr_sel,
	output nfr_pkg::nfr_ecc_cfg_t cfg
);
	import nfr_pkg::*;

	always_comb begin
		cfg = '0;
		cfg.page_size_sel   = page_sel;
		cfg.correction_type = corr_sel;
		case (page_sel)
			PS_512_16: begin
				cfg.main_bytes  = MAIN_512;
				cfg.spare_bytes = SPARE_16;
			end
			PS_1024_32: begin
				cfg.main_bytes  = MAIN_1024;
				cfg.spare_bytes = SPARE_32;
			end
			PS_2048_64: begin
				cfg.main_bytes  = MAIN_2048;
				cfg.spare_bytes = SPARE_64;
			end
			default: begin
				cfg.main_bytes  = MAIN_4096;
				cfg.spare_bytes = SPARE_128;
			end
		endcase
		case (corr_sel)
			CT_256:  cfg.corr_span = SPAN_256;
			CT_512:  cfg.corr_span = SPAN_512;
			default: cfg.corr_span = SPAN_PAGE;
		endcase
	end

endmodule

// [hw/nfr_event_flag.sv]
// Sticky event flag, set by hardware, cleared by status read
`timescale 1ns/1ps
module nfr_event_flag (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic set_evt,
	input  wire logic clr_rd,
	input  wire logic clr_sw,
	output logic      flag_q
);
	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_rd || clr_sw) begin
			flag_q <= 1'b0;
		end
	end

	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		set_evt |=> flag_q)
		else $error("event flag lost on set");

endmodule

// [hw/nfr_regs.sv]
// NAND controller register slice: interrupt mask, address byte, bank, ECC control and mode
//
// Contract
// [RULE1] Writing one to a bit of irq_disable_reg turns that source off; zeros change nothing.
// [RULE2] irq_mask_status reads one per enabled source and zero otherwise, resetting to zero.
// [RULE3] Ready rising edge sits at bit 4, falling edge at bit 5, line edge at bit 24.
// [RULE4] Transfer complete sits at bit 16 and command complete at bit 17.
// [RULE5] Timeout bit 20, unmapped area bit 21, access while busy bit 22, size error bit 23.
// [RULE6] The line edge source has a mask bit reading one when enabled and zero when disabled.
// [RULE7] address_cycle_zero holds a read/write byte, reset zero, sent first with five cycles.
// [RULE8] nand_bank_select holds a read/write bank number, reset zero, used as the target bank.
// [RULE9] Writing one to bit 0 of parity_control clears all parity registers; zero does nothing.
// [RULE10] Writing one to bit 1 of parity_control resets all ECC registers; zero does nothing.
// [RULE11] Page size field 1:0 decodes 0..3 to 512+16, 1024+32, 2048+64 and 4096+128 bytes.
// [RULE12] Correction type 0 whole page, 1 per 256 bytes, 2 per 512 bytes (both 8-bit only).
// [RULE13] Each event flag clears when software reads controller_status_reg; a flag whose event arrives in the same cycle as the read stays set.
// [RULE14] Writing one to a bit of irq_enable_reg turns that source on; zeros change nothing.
// [RULE15] The interrupt output is high while any event flag is set with its mask bit one.
`timescale 1ns/1ps
module nfr_regs #(
	parameter int BANK_WIDTH = nfr_pkg::BANK_W
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST_N,
	input  wire logic [31:0]           REG_ADDR,
	input  wire logic [31:0]           REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic      [31:0]           REG_RDATA,
	input  wire logic [nfr_pkg::NUM_SRC-1:0] EVENT_IN,
	output logic                       IRQ,
	output logic      [7:0]            FIRST_ADDRESS_BYTE,
	output logic      [BANK_WIDTH-1:0] BANK_SEL,
	output logic                       PARITY_CLEAR,
	output logic                       ECC_SOFT_RESET,
	output nfr_pkg::nfr_ecc_cfg_t      ECC_CFG
);
	import nfr_pkg::*;

	// ==========================================================
	// Bus capture
	nfr_bus_t bus;
	assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

	logic wr_en;
	logic wr_dis;
	logic wr_addr0;
	logic wr_bank;
	logic wr_pctrl;
	logic wr_pmode;
	logic rd_status;
	logic soft_rst;

	assign wr_en     = bus.wr && (bus.addr == IRQ_EN_OFF);
	assign wr_dis    = bus.wr && (bus.addr == IRQ_DIS_OFF);
	assign wr_addr0  = bus.wr && (bus.addr == ADDR0_OFF);
	assign wr_bank   = bus.wr && (bus.addr == BANK_OFF);
	assign wr_pctrl  = bus.wr && (bus.addr == PCTRL_OFF);
	assign wr_pmode  = bus.wr && (bus.addr == PMODE_OFF);
	assign rd_status = bus.rd && (bus.addr == STATUS_OFF);
	assign soft_rst  = wr_pctrl && bus.wdata[SOFT_RST_BIT];

	// ==========================================================
	// Interrupt mask: set by enable, cleared by disable
	logic [31:0] mask_q;
	logic [31:0] mask_d;

	always_comb begin
		mask_d = mask_q;
		if (wr_en) begin
			mask_d = mask_d | (bus.wdata & SRC_MASK); // [RULE14]
		end
		if (wr_dis) begin
			mask_d = mask_d & ~(bus.wdata & SRC_MASK); // [RULE1]
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_q <= ZERO32; // [RULE2]
		end else begin
			mask_q <= mask_d;
		end
	end

	// ==========================================================
	// Event flags, placed at their status bit positions
	logic [31:0] status_w;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			logic flag;
			nfr_event_flag u_flag (
				.clk     (CORE_CLK),
				.rst_n   (RST_N),
				.set_evt (EVENT_IN[g]),
				.clr_rd  (rd_status), // [RULE13]
				.clr_sw  (1'b0),
				.flag_q  (flag)
			);
		end
	endgenerate

	always_comb begin
		status_w = ZERO32;
		status_w[RISE_BIT]  = g_src[0].flag; // [RULE3]
		status_w[FALL_BIT]  = g_src[1].flag; // [RULE3]
		status_w[XFER_BIT]  = g_src[2].flag; // [RULE4]
		status_w[CMD_BIT]   = g_src[3].flag; // [RULE4]
		status_w[DTO_BIT]   = g_src[4].flag; // [RULE5]
		status_w[UNMAP_BIT] = g_src[5].flag; // [RULE5]
		status_w[BUSY_BIT]  = g_src[6].flag; // [RULE5]
		status_w[SIZE_BIT]  = g_src[7].flag; // [RULE5]
		status_w[LEDGE_BIT] = g_src[8].flag; // [RULE6]
	end

	// Level interrupt from any enabled pending flag
	assign IRQ = |(status_w & mask_q); // [RULE15]

	// ==========================================================
	// Address byte and bank
	logic [7:0]            addr0_q;
	logic [BANK_WIDTH-1:0] bank_q;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr0_q <= ADDR0_RST;
		end else if (wr_addr0) begin
			addr0_q <= bus.wdata[7:0]; // [RULE7]
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bank_q <= '0;
		end else if (wr_bank) begin
			bank_q <= bus.wdata[BANK_WIDTH-1:0]; // [RULE8]
		end
	end

	assign FIRST_ADDRESS_BYTE = addr0_q; // [RULE7]
	assign BANK_SEL           = bank_q; // [RULE8]

	// ==========================================================
	// ECC control pulses and mode register
	logic       par_clr_q;
	logic       soft_rst_q;
	nfr_page_t  page_q;
	nfr_corr_t  corr_q;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			par_clr_q  <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			// Soft reset also clears parity
			par_clr_q  <= (wr_pctrl && bus.wdata[PAR_CLR_BIT]) || soft_rst; // [RULE9]
			soft_rst_q <= soft_rst; // [RULE10]
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			page_q <= PS_512_16;
			corr_q <= CT_PAGE;
		end else if (soft_rst) begin
			page_q <= PS_512_16; // [RULE10]
			corr_q <= CT_PAGE;
		end else if (wr_pmode) begin
			page_q <= nfr_page_t'(bus.wdata[PS_LSB+:2]); // [RULE11]
			corr_q <= nfr_corr_t'(bus.wdata[CT_LSB+:2]); // [RULE12]
		end
	end

	assign PARITY_CLEAR   = par_clr_q;
	assign ECC_SOFT_RESET = soft_rst_q;

	nfr_ecc_decode u_dec (
		.page_sel (page_q), // [RULE11]
		.corr_sel (corr_q), // [RULE12]
		.cfg      (ECC_CFG)
	);

	// ==========================================================
	// Read data, one cycle after the strobe
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;

	always_comb begin
		rdata_d = ZERO32;
		if (bus.rd) begin
			case (bus.addr)
				STATUS_OFF:   rdata_d = status_w;
				IRQ_MASK_OFF: rdata_d = mask_q; // [RULE2]
				ADDR0_OFF:    rdata_d = {24'h000000, addr0_q};
				BANK_OFF:     rdata_d = 32'(bank_q);
				PMODE_OFF:    rdata_d = 32'({corr_q, 2'h0, page_q});
				default:      rdata_d = ZERO32;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_q <= ZERO32;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;

	// ==========================================================
	// Checks
	a_disable_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE1]
		(wr_dis && !wr_en) |=> ((mask_q & $past(bus.wdata)) == ZERO32))
		else $error("disable write left source on");

	a_enable_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE14]
		(wr_en && !wr_dis) |=> ((mask_q & $past(bus.wdata) & SRC_MASK)
			== ($past(bus.wdata) & SRC_MASK)))
		else $error("enable write missed a source");

	a_mask_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE2]
		(!wr_en && !wr_dis) |=> $stable(mask_q))
		else $error("mask changed without a write");

	a_mask_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE2]
		(bus.rd && bus.addr == IRQ_MASK_OFF) |=> (REG_RDATA == $past(mask_q)))
		else $error("mask readback wrong");

	a_status_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE13]
		(rd_status && EVENT_IN == '0) |=> (status_w == ZERO32))
		else $error("status read did not clear flags");

	a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE15]
		(EVENT_IN[2] && mask_q[XFER_BIT] && !wr_dis) |=> IRQ)
		else $error("enabled event did not raise interrupt");

	a_addr_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE7]
		wr_addr0 |=> (FIRST_ADDRESS_BYTE == $past(bus.wdata[7:0])))
		else $error("address byte not stored");

	a_bank_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE8]
		wr_bank |=> (BANK_SEL == $past(bus.wdata[BANK_WIDTH-1:0])))
		else $error("bank not stored");

	a_parity_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE9]
		(wr_pctrl && bus.wdata[PAR_CLR_BIT]) |=> PARITY_CLEAR)
		else $error("parity clear pulse missing");

	a_parity_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE9]
		!wr_pctrl |=> (!PARITY_CLEAR && !ECC_SOFT_RESET))
		else $error("ECC control pulse without a write");

	a_parity_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE9]
		(wr_pctrl && !bus.wdata[PAR_CLR_BIT] && !soft_rst) |=> !PARITY_CLEAR)
		else $error("parity clear on a zero write");

	a_soft_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE10]
		soft_rst |=> (ECC_SOFT_RESET && page_q == PS_512_16 && corr_q == CT_PAGE))
		else $error("soft reset did not restore mode");

	a_page_decode: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE11]
		(page_q == PS_2048_64) |-> (ECC_CFG.main_bytes == MAIN_2048
			&& ECC_CFG.spare_bytes == SPARE_64))
		else $error("page size decode wrong");

	a_corr_decode: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE12]
		(wr_pmode && !soft_rst && bus.wdata[CT_LSB+:2] == CT_256)
			|=> (ECC_CFG.corr_span == SPAN_256))
		else $error("correction span decode wrong");

	a_soft_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE10]
		(wr_pctrl && !soft_rst) |=> !ECC_SOFT_RESET)
		else $error("soft reset on a zero write");

	a_mask_sources: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE3]
		((mask_q & ~SRC_MASK) == ZERO32))
		else $error("mask bit set outside the sources");

	a_edge_enable: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE6]
		(wr_en && bus.wdata[LEDGE_BIT]) |=> mask_q[LEDGE_BIT])
		else $error("line edge source not enabled");

	a_edge_disable: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE6]
		(wr_dis && bus.wdata[LEDGE_BIT]) |=> !mask_q[LEDGE_BIT])
		else $error("line edge source not disabled");

	a_cmd_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE4]
		EVENT_IN[3] |=> status_w[CMD_BIT])
		else $error("command complete flag misplaced");

	a_size_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE5]
		EVENT_IN[7] |=> status_w[SIZE_BIT])
		else $error("access size flag misplaced");

	a_status_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE13]
		rd_status |=> (REG_RDATA == $past(status_w)))
		else $error("status readback wrong");

	a_irq_cleared: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE15]
		(rd_status && EVENT_IN == '0) |=> !IRQ)
		else $error("interrupt stayed high after status read");

	a_addr_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE7]
		(bus.rd && bus.addr == ADDR0_OFF) |=> (REG_RDATA == {24'h000000, $past(addr0_q)}))
		else $error("address byte readback wrong");

	a_bank_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE8]
		(bus.rd && bus.addr == BANK_OFF) |=> (REG_RDATA[BANK_WIDTH-1:0] == $past(bank_q)))
		else $error("bank readback wrong");

	a_ctrl_writeonly: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [RULE9]
		(bus.rd && bus.addr == PCTRL_OFF) |=> (REG_RDATA == ZERO32))
		else $error("write-only control read nonzero");

endmodule

// [tb/nfr_nand_model.sv]
// Far-side model: raises one event pulse per request
`timescale 1ns/1ps
module nfr_nand_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       fire,
	input  wire logic [3:0] which,
	output logic      [8:0] evt
);
	// ====
	// One-cycle pulse on the requested source line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt <= 9'h000;
		end else begin
			evt <= fire ? 9'(9'h001 << which) : 9'h000;
		end
	end
endmodule

// [tb/nand_ctrl_irq_ecc_regs_test.sv]
// Self-checking bench for the NAND register slice
`timescale 1ns/1ps
module nand_ctrl_irq_ecc_regs_test;
	import nfr_pkg::*;
	logic         clk, rst_n, wr, rd, fire, rd_q, irq, pclr, srst;
	logic  [31:0] addr, wdata, rdata, mask_e, seed;
	logic  [3:0]  which;
	logic  [8:0]  evt;
	logic  [7:0]  fab;
	logic  [2:0]  bank;
	nfr_ecc_cfg_t cfg;
	logic  [31:0] exp_q[$];
	int           bad_count, samples_checked;
	int           pos[9] = '{4, 5, 16, 17, 20, 21, 22, 23, 24};
	logic  [31:0] offs[9] = '{IRQ_MASK_OFF, ADDR0_OFF, BANK_OFF, PCTRL_OFF, PMODE_OFF,
		32'h400e0030, IRQ_EN_OFF, IRQ_DIS_OFF, IRQ_MASK_OFF};

	nfr_regs #(.BANK_WIDTH(3)) nfr_regs_inst (
		.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EVENT_IN(evt), .IRQ(irq),
		.FIRST_ADDRESS_BYTE(fab), .BANK_SEL(bank), .PARITY_CLEAR(pclr),
		.ECC_SOFT_RESET(srst), .ECC_CFG(cfg)
	);
	nfr_nand_model nfr_nand_model_inst (
		.clk(clk), .rst_n(rst_n), .fire(fire), .which(which), .evt(evt)
	);

	// ====
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic fire_evt(input int i);
		@(posedge clk);
		fire <= 1'b1;
		which <= 4'(i);
		@(posedge clk);
		fire <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ====
	// Clock, watchdog and read-data monitor
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (50000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	always @(negedge clk) begin
		if (rd_q) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("[FAIL] %0t read data without expectation", $time);
			end else begin
				chk(rdata, exp_q.pop_front());
			end
		end
		rd_q = rd;
	end

	// ====
	// Main sequence
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		fire = 1'b0;
		which = 4'h0;
		addr = 32'h0;
		wdata = 32'h0;
		mask_e = 32'h0;
		seed = 32'h58889981;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, write-only, unmapped and read-only places
		for (int k = 0; k < 9; k++) begin
			if (k == 8) wr_reg(IRQ_MASK_OFF, 32'hffffffff);
			rd_reg(offs[k], 32'h0);
		end
		for (int i = 0; i < 9; i++) begin
			wr_reg(IRQ_EN_OFF, 32'h1 << pos[i]);
			mask_e[pos[i]] = 1'b1;
			rd_reg(IRQ_MASK_OFF, mask_e);
		end
		repeat (4) begin
			seed = xs(seed);
			wr_reg(IRQ_DIS_OFF, seed);
			mask_e = mask_e & ~(seed & SRC_MASK);
			rd_reg(IRQ_MASK_OFF, mask_e);
			wr_reg(IRQ_EN_OFF, ~seed);
			mask_e = mask_e | (~seed & SRC_MASK);
			rd_reg(IRQ_MASK_OFF, mask_e);
		end
		// Events: all sources on, odd ones masked out in turn
		wr_reg(IRQ_EN_OFF, SRC_MASK);
		mask_e = SRC_MASK;
		for (int i = 0; i < 9; i++) begin
			if (i % 2 == 1) wr_reg(IRQ_DIS_OFF, 32'h1 << pos[i]);
			fire_evt(i);
			chk(32'(irq), 32'(i % 2 == 0));
			rd_reg(STATUS_OFF, 32'h1 << pos[i]);
			#1;
			chk(32'(irq), 32'h0);
			rd_reg(STATUS_OFF, 32'h0);
			wr_reg(IRQ_EN_OFF, 32'h1 << pos[i]);
		end
		// Event and status read in one cycle: the set wins
		fork
			fire_evt(2);
			begin
				@(posedge clk);
				rd_reg(STATUS_OFF, 32'h0);
			end
		join
		chk(32'(irq), 32'h1);
		rd_reg(STATUS_OFF, 32'h1 << XFER_BIT);
		#1;
		chk(32'(irq), 32'h0);
		repeat (4) begin
			seed = xs(seed);
			wr_reg(ADDR0_OFF, seed);
			wr_reg(BANK_OFF, seed >> 8);
			rd_reg(ADDR0_OFF, {24'h0, seed[7:0]});
			rd_reg(BANK_OFF, {29'h0, seed[10:8]});
			chk(32'(fab), 32'(seed[7:0]));
			chk(32'(bank), 32'(seed[10:8]));
		end
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 4; c++) begin
				wr_reg(PMODE_OFF, 32'(c * 16 + p));
				rd_reg(PMODE_OFF, 32'(c * 16 + p));
				chk(32'(cfg.main_bytes), 32'(512 << p));
				chk(32'(cfg.spare_bytes), 32'(16 << p));
				chk(32'(cfg.page_size_sel), 32'(p));
				chk(32'(cfg.correction_type), 32'(c));
				chk(32'(cfg.corr_span), 32'((c % 3) * 256));
			end
		end
		// Parity clear and soft reset pulses
		wr_reg(PCTRL_OFF, 32'hfffffffc);
		#1;
		chk(32'({pclr, srst}), 32'h0);
		wr_reg(PCTRL_OFF, 32'h1);
		#1;
		chk(32'({pclr, srst}), 32'h2);
		@(posedge clk);
		#1;
		chk(32'(pclr), 32'h0);
		wr_reg(PCTRL_OFF, 32'h2);
		#1;
		chk(32'({pclr, srst}), 32'h3);
		chk(32'(cfg.main_bytes), 32'(MAIN_512));
		rd_reg(PMODE_OFF, 32'h0);
		rd_reg(ADDR0_OFF, {24'h0, seed[7:0]});
		rd_reg(IRQ_MASK_OFF, mask_e);
		// Mid-run reset
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(IRQ_MASK_OFF, 32'h0);
		rd_reg(ADDR0_OFF, 32'h0);
		rd_reg(BANK_OFF, 32'h0);
		chk(32'(fab), 32'h0);
		chk(32'(irq), 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(exp_q.size()), 32'h0);
		report_and_stop();
	end
endmodule
